// *** replay_core.sv ***
// waveform replay block: command, wait limit, two memory channels, wishbone slave
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
module replay_core
#(
    parameter int ADDR_W = 12,
    parameter int CYCLES_PER_MS = replay_pkg::MS_CYCLES
)
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic trigger_i,
    output logic [7:0] dac0_o,
    output logic [7:0] dac1_o,
    output logic [7:0] dac2_o,
    output logic [7:0] dac3_o,
    output logic sample_valid_o,
    output logic running_o,
    output logic irq_o
);
    import replay_pkg::*;

    localparam int DEPTH = 1 << ADDR_W;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // word address of a sample step inside one memory channel
    function automatic logic [ADDR_W-1:0] word_addr(input logic [31:0] idx,
                                                   input logic inter, input logic odd);
        logic [31:0] a;
        a = inter ? {idx[30:0], odd} : idx;
        return a[ADDR_W-1:0];
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
                r[8*b +: 8] = nw[8*b +: 8];
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic req;
    logic wr;
    logic [29:0] idx;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i;
    assign idx = wb_adr_i[31:2];

    logic [31:0] command_r;
    logic [31:0] wait_limit_r;
    logic [1:0] mode_r;
    logic [31:0] length_r;
    logic mem_sel_r;
    logic [31:0] mem_pos_r;
    logic trig_wait_r;
    logic [2:0] ev_stat_r;
    logic [2:0] ev_mask_r;
    logic [1:0] result_r;
    run_state_t state_r;

    logic cmd_launch;
    logic cmd_halt;
    assign cmd_launch = wr && idx == IDX_COMMAND_WORD && wb_sel_i != 4'h0
                        && merge(command_r, wb_dat_i, wb_sel_i) == LAUNCH_AND_BLOCK_CODE;
    assign cmd_halt = wr && idx == IDX_COMMAND_WORD && wb_sel_i != 4'h0
                      && merge(command_r, wb_dat_i, wb_sel_i) == HALT_CODE;

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            command_r <= RESET_WORD;
            wait_limit_r <= RESET_WORD;
            mode_r <= MODE_CH0;
            length_r <= RESET_WORD;
            mem_sel_r <= 1'b0;
            trig_wait_r <= 1'b0;
            ev_mask_r <= RESET_EVENTS;
        end
        else if (wr)
        begin
            unique case (idx)
                IDX_COMMAND_WORD: command_r <= merge(command_r, wb_dat_i, wb_sel_i);
                IDX_WAIT_LIMIT_MS: wait_limit_r <= merge(wait_limit_r, wb_dat_i, wb_sel_i);
                IDX_CHANNEL_MODE: if (wb_sel_i[0]) mode_r <= wb_dat_i[1:0];
                IDX_REPLAY_LENGTH: length_r <= merge(length_r, wb_dat_i, wb_sel_i);
                IDX_MEM_SELECT: if (wb_sel_i[0]) mem_sel_r <= wb_dat_i[0];
                IDX_TRIGGER_CFG: if (wb_sel_i[0]) trig_wait_r <= wb_dat_i[0];
                IDX_EVENT_MASK: if (wb_sel_i[0]) ev_mask_r <= wb_dat_i[2:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // sample memories
    // ------------------------------------------------------------
    logic [15:0] mem0 [DEPTH];
    logic [15:0] mem1 [DEPTH];
    logic data_wr;
    assign data_wr = wr && idx == IDX_MEM_DATA && wb_sel_i[1:0] == 2'h3;

    // position in samples, auto-advancing after each data write that selects byte lanes 0 and 1
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            mem_pos_r <= RESET_WORD;
        else if (wr && idx == IDX_MEM_POSITION)
            mem_pos_r <= merge(mem_pos_r, wb_dat_i, wb_sel_i);
        else if (data_wr)
            mem_pos_r <= mem_pos_r + 32'h00000001;
    end

    // out-of-range positions are dropped
    always_ff @(posedge clk_i)
    begin
        if (data_wr && mem_pos_r < DEPTH)
        begin
            if (mem_sel_r)
                mem1[mem_pos_r[ADDR_W-1:0]] <= wb_dat_i[15:0];
            else
                mem0[mem_pos_r[ADDR_W-1:0]] <= wb_dat_i[15:0];
        end
    end

    // ------------------------------------------------------------
    // trigger pin synchroniser
    // ------------------------------------------------------------
    logic trig_s1_r;
    logic trig_s2_r;
    logic trig_s3_r;
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            trig_s1_r <= 1'b0;
            trig_s2_r <= 1'b0;
            trig_s3_r <= 1'b0;
        end
        else
        begin
            trig_s1_r <= trigger_i;
            trig_s2_r <= trig_s1_r;
            trig_s3_r <= trig_s2_r;
        end
    end

    logic trig_edge;
    assign trig_edge = trig_s2_r && !trig_s3_r;

    // ------------------------------------------------------------
    // wait limit timer
    // ------------------------------------------------------------
    logic [31:0] tick_cnt_r;
    logic [31:0] ms_cnt_r;
    logic busy;
    logic expired;
    assign busy = state_r != ST_IDLE;
    assign expired = busy && wait_limit_r != RESET_WORD && ms_cnt_r >= wait_limit_r;

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            tick_cnt_r <= RESET_WORD;
            ms_cnt_r <= RESET_WORD;
        end
        else if (!busy)
        begin
            tick_cnt_r <= RESET_WORD;
            ms_cnt_r <= RESET_WORD;
        end
        else if (tick_cnt_r == 32'(CYCLES_PER_MS - 1))
        begin
            tick_cnt_r <= RESET_WORD;
            ms_cnt_r <= ms_cnt_r + 32'h00000001;
        end
        else
            tick_cnt_r <= tick_cnt_r + 32'h00000001;
    end

    // ------------------------------------------------------------
    // replay sequencer
    // ------------------------------------------------------------
    logic [31:0] step_r;
    logic phase_r;
    logic inter;
    logic last_step;
    assign inter = mode_r == MODE_CH01 || mode_r == MODE_CH0123;
    assign last_step = phase_r && step_r + 32'h00000001 >= length_r;

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            state_r <= ST_IDLE;
        else if (cmd_halt || expired)
            state_r <= ST_IDLE;
        else
        begin
            unique case (state_r)
                ST_IDLE: if (cmd_launch) state_r <= trig_wait_r ? ST_ARMED : ST_PLAY;
                ST_ARMED: if (trig_edge) state_r <= ST_PLAY;
                ST_PLAY: if (last_step) state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            step_r <= RESET_WORD;
            phase_r <= 1'b0;
        end
        else if (state_r != ST_PLAY)
        begin
            step_r <= RESET_WORD;
            phase_r <= 1'b0;
        end
        else
        begin
            phase_r <= !phase_r;
            if (phase_r)
                step_r <= step_r + 32'h00000001;
        end
    end

    // ------------------------------------------------------------
    // dac output path
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            dac0_o <= 8'h00;
            dac1_o <= 8'h00;
            dac2_o <= 8'h00;
            dac3_o <= 8'h00;
            sample_valid_o <= 1'b0;
        end
        else
        begin
            sample_valid_o <= state_r == ST_PLAY && phase_r && !cmd_halt && !expired;
            if (state_r == ST_PLAY && !phase_r)
            begin
                dac0_o <= mem0[word_addr(step_r, inter, 1'b0)][7:0];
                if (mode_r == MODE_CH02 || mode_r == MODE_CH0123)
                    dac2_o <= mem1[word_addr(step_r, inter, 1'b0)][7:0];
            end
            else if (state_r == ST_PLAY && inter)
            begin
                dac1_o <= mem0[word_addr(step_r, inter, 1'b1)][7:0];
                if (mode_r == MODE_CH0123)
                    dac3_o <= mem1[word_addr(step_r, inter, 1'b1)][7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // wait result and events
    // ------------------------------------------------------------
    logic ev_done;
    logic ev_timeout;
    logic ev_halt;
    assign ev_done = state_r == ST_PLAY && last_step && !cmd_halt && !expired;
    assign ev_timeout = expired && !cmd_halt;
    assign ev_halt = cmd_halt && busy;

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            result_r <= RESULT_NONE;
        else if (cmd_launch && !busy)
            result_r <= RESULT_NONE;
        else if (ev_done)
            result_r <= RESULT_DONE;
        else if (ev_timeout)
            result_r <= RESULT_TIMEOUT;
        else if (ev_halt)
            result_r <= RESULT_HALTED;
    end

    // set wins over write-one-to-clear
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            ev_stat_r <= RESET_EVENTS;
        else
        begin
            for (int b = 0; b < 3; b++)
            begin
                if ((b == EV_DONE && ev_done) || (b == EV_TIMEOUT && ev_timeout)
                    || (b == EV_HALTED && ev_halt))
                    ev_stat_r[b] <= 1'b1;
                else if (wr && idx == IDX_EVENT_STATUS && wb_sel_i[0] && wb_dat_i[b])
                    ev_stat_r[b] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            irq_o <= 1'b0;
            running_o <= 1'b0;
        end
        else
        begin
            irq_o <= |(ev_stat_r & ev_mask_r);
            running_o <= busy;
        end
    end

    // ------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= RESET_WORD;
        end
        else
        begin
            wb_ack_o <= req;
            if (req && !wb_we_i)
            begin
                unique case (idx)
                    IDX_COMMAND_WORD: wb_dat_o <= command_r;
                    IDX_WAIT_LIMIT_MS: wb_dat_o <= wait_limit_r;
                    IDX_CHANNEL_MODE: wb_dat_o <= {30'h0, mode_r};
                    IDX_REPLAY_LENGTH: wb_dat_o <= length_r;
                    IDX_MEM_SELECT: wb_dat_o <= {31'h0, mem_sel_r};
                    IDX_MEM_POSITION: wb_dat_o <= mem_pos_r;
                    IDX_RUN_STATUS: wb_dat_o <= {29'h0, state_r};
                    IDX_WAIT_RESULT: wb_dat_o <= {30'h0, result_r};
                    IDX_EVENT_STATUS: wb_dat_o <= {29'h0, ev_stat_r};
                    IDX_EVENT_MASK: wb_dat_o <= {29'h0, ev_mask_r};
                    IDX_TRIGGER_CFG: wb_dat_o <= {31'h0, trig_wait_r};
                    default: wb_dat_o <= RESET_WORD;
                endcase
            end
        end
    end

endmodule // replay_core

// *** replay_pkg.sv ***
// constants, register map and types for the waveform replay block
package replay_pkg;

    // ------------------------------------------------------------
    // register indices (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [29:0] IDX_COMMAND_WORD = 30'h0000000;
    localparam logic [29:0] IDX_WAIT_LIMIT_MS = 30'h00480DA;
    localparam logic [29:0] IDX_CHANNEL_MODE = 30'h0000001;
    localparam logic [29:0] IDX_REPLAY_LENGTH = 30'h0000002;
    localparam logic [29:0] IDX_MEM_SELECT = 30'h0000003;
    localparam logic [29:0] IDX_MEM_POSITION = 30'h0000004;
    localparam logic [29:0] IDX_MEM_DATA = 30'h0000005;
    localparam logic [29:0] IDX_RUN_STATUS = 30'h0000006;
    localparam logic [29:0] IDX_WAIT_RESULT = 30'h0000007;
    localparam logic [29:0] IDX_EVENT_STATUS = 30'h0000008;
    localparam logic [29:0] IDX_EVENT_MASK = 30'h0000009;
    localparam logic [29:0] IDX_TRIGGER_CFG = 30'h000000A;

    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [31:0] LAUNCH_AND_BLOCK_CODE = 32'h0000000B;
    localparam logic [31:0] HALT_CODE = 32'h00000014;

    // ------------------------------------------------------------
    // channel modes
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_CH0 = 2'h0;
    localparam logic [1:0] MODE_CH01 = 2'h1;
    localparam logic [1:0] MODE_CH02 = 2'h2;
    localparam logic [1:0] MODE_CH0123 = 2'h3;

    // ------------------------------------------------------------
    // wait results and event bits
    // ------------------------------------------------------------
    localparam logic [1:0] RESULT_NONE = 2'h0;
    localparam logic [1:0] RESULT_DONE = 2'h1;
    localparam logic [1:0] RESULT_TIMEOUT = 2'h2;
    localparam logic [1:0] RESULT_HALTED = 2'h3;
    localparam int EV_DONE = 0;
    localparam int EV_TIMEOUT = 1;
    localparam int EV_HALTED = 2;

    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [31:0] RESET_WORD = 32'h00000000;
    localparam logic [2:0] RESET_EVENTS = 3'h0;
    localparam int CLK_PERIOD_NS = 10;
    localparam int ONE_MS_NS = 1000000;
    localparam int MS_CYCLES = (ONE_MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_ARMED = 3'b010,
        ST_PLAY = 3'b100
    } run_state_t;

endpackage

// *** replay_core_properties.sv ***
// port-level checks for the replay block
`timescale 1ns/1ps
module replay_core_properties
    import replay_pkg::*;
#(
    parameter int CYCLES_PER_MS = MS_CYCLES
)
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic running_o,
    input wire logic sample_valid_o,
    input wire logic irq_o
);
    logic req;
    logic cmd_wr;
    logic [31:0] lim_r;
    int run_cnt;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign cmd_wr = req && wb_we_i && wb_sel_i == 4'hF && wb_adr_i[31:2] == IDX_COMMAND_WORD;
    // shadow of the wait limit, snooped from bus writes
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            lim_r <= 32'h0;
        else if (req && wb_we_i && wb_sel_i == 4'hF && wb_adr_i[31:2] == IDX_WAIT_LIMIT_MS)
            lim_r <= wb_dat_i;
    end
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            run_cnt <= 0;
        else if (!running_o)
            run_cnt <= 0;
        else
            run_cnt <= run_cnt + 1;
    end
    property p_ack_answer; req |=> wb_ack_o; endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request not acked");
    property p_ack_single; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_single: assert property (p_ack_single) else $error("ack longer than one cycle");
    property p_launch;
        cmd_wr && wb_dat_i == LAUNCH_AND_BLOCK_CODE && !running_o |-> ##[2:3] running_o;
    endproperty
    a_launch: assert property (p_launch) else $error("launch did not start");
    property p_halt; cmd_wr && wb_dat_i == HALT_CODE |-> ##3 !running_o; endproperty
    a_halt: assert property (p_halt) else $error("halt did not stop");
    property p_idle_halt;
        (!running_o) [*4] ##0 (cmd_wr && wb_dat_i == HALT_CODE) |=>
            (!running_o && $stable(irq_o)) [*3];
    endproperty
    a_idle_halt: assert property (p_idle_halt) else $error("idle halt had effect");
    property p_valid_single; sample_valid_o |=> !sample_valid_o; endproperty
    a_valid_single: assert property (p_valid_single) else $error("steps too close");
    property p_valid_busy; sample_valid_o |-> running_o; endproperty
    a_valid_busy: assert property (p_valid_busy) else $error("step while idle");
    property p_rise_idle; $rose(irq_o) |-> !running_o; endproperty
    a_rise_idle: assert property (p_rise_idle) else $error("irq before stop");
    property p_wait_bound; lim_r != 0 |-> run_cnt <= lim_r * CYCLES_PER_MS + 8; endproperty
    a_wait_bound: assert property (p_wait_bound) else $error("wait limit overrun");
endmodule // replay_core_properties

bind replay_core replay_core_properties #(.CYCLES_PER_MS(CYCLES_PER_MS)) props (
    .clk_i(clk_i), .reset_i(reset_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .running_o(running_o),
    .sample_valid_o(sample_valid_o), .irq_o(irq_o));

// *** dac_sink.sv ***
// output-path model: captures dac steps and drives the trigger pin
`timescale 1ns/1ps
module dac_sink
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [7:0] dac0_i,
    input wire logic [7:0] dac1_i,
    input wire logic [7:0] dac2_i,
    input wire logic [7:0] dac3_i,
    input wire logic sample_valid_i,
    output logic trigger_o
);
    logic [7:0] cap [0:3][0:7];
    int cnt = 0;
    initial trigger_o = 1'b0;
    // dac values are settled while the step pulse is high
    always @(posedge clk_i)
    begin
        if (reset_i)
            cnt <= 0;
        else if (sample_valid_i === 1'b1 && cnt < 8)
        begin
            cap[0][cnt] <= dac0_i;
            cap[1][cnt] <= dac1_i;
            cap[2][cnt] <= dac2_i;
            cap[3][cnt] <= dac3_i;
            cnt <= cnt + 1;
        end
    end
    task automatic fire;
        @(posedge clk_i);
        trigger_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        trigger_o <= 1'b0;
    endtask
endmodule // dac_sink

// *** replay_core_bench.sv ***
// self-checking bench for the replay block
`timescale 1ns/1ps
module replay_core_bench;
    import replay_pkg::*;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [31:0] wb_adr_i = 32'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'hF;
    logic wb_we_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic [31:0] wb_dat_o;
    logic [31:0] q;
    logic wb_ack_o, trigger_i, sample_valid_o, running_o, irq_o;
    logic [7:0] dac0_o, dac1_o, dac2_o, dac3_o;
    int err_total = 0;
    int n_tests = 0;
    int k;
    always #5 clk_i = ~clk_i;
    replay_core #(.CYCLES_PER_MS(10)) uut (.clk_i(clk_i), .reset_i(reset_i),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .trigger_i(trigger_i), .dac0_o(dac0_o), .dac1_o(dac1_o), .dac2_o(dac2_o),
        .dac3_o(dac3_o), .sample_valid_o(sample_valid_o), .running_o(running_o),
        .irq_o(irq_o));
    dac_sink sink (.clk_i(clk_i), .reset_i(reset_i), .dac0_i(dac0_o), .dac1_i(dac1_o),
        .dac2_i(dac2_o), .dac3_i(dac3_o), .sample_valid_i(sample_valid_o),
        .trigger_o(trigger_i));
    function automatic logic [7:0] smp(input int m, input int i);
        return (m == 0 && i == 2) ? 8'h55 : 8'(8'h7E + 8'h40 * m + i);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [29:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= {idx, 2'h0};
        wb_dat_i <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 64);
        if (n >= 64)
            chk({31'h0, wb_ack_o}, 32'h1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task automatic wr(input logic [29:0] idx, input logic [31:0] d);
        xfer(1'b1, idx, d);
    endtask
    task automatic rd(input logic [29:0] idx, input logic [31:0] exp);
        xfer(1'b0, idx, 32'h0);
        chk(q, exp);
    endtask
    // wait for the interrupt, check the outcome, clear the event
    task automatic close_run(input logic [31:0] res, input logic [31:0] ev);
        int n;
        n = 0;
        while (irq_o !== 1'b1 && n < 400)
        begin
            @(negedge clk_i);
            n++;
        end
        chk({31'h0, irq_o}, 32'h1);
        rd(IDX_WAIT_RESULT, res);
        rd(IDX_EVENT_STATUS, ev);
        wr(IDX_EVENT_STATUS, 32'h7);
        rd(IDX_RUN_STATUS, 32'h1);
        chk({31'h0, irq_o}, 32'h0);
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        finish_test;
    end
    initial
    begin
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        rd(IDX_RUN_STATUS, 32'h1);
        rd(30'h00000FF, 32'h0);
        wr(IDX_WAIT_LIMIT_MS, 32'h5);
        rd(IDX_WAIT_LIMIT_MS, 32'h5);
        wr(IDX_WAIT_LIMIT_MS, 32'h0);
        wr(IDX_EVENT_MASK, 32'h7);
        for (int m = 0; m < 2; m++)
        begin
            wr(IDX_MEM_SELECT, 32'(m));
            wr(IDX_MEM_POSITION, 32'h0);
            for (int i = 0; i < 4; i++)
                wr(IDX_MEM_DATA, {24'hA5, 8'(8'h7E + 8'h40 * m + i)});
        end
        wr(IDX_MEM_SELECT, 32'h0);
        wr(IDX_MEM_POSITION, 32'h2);
        wr(IDX_MEM_DATA, 32'h0055);
        wr(IDX_REPLAY_LENGTH, 32'h2);
        for (int md = 0; md < 4; md++)
        begin
            wr(IDX_CHANNEL_MODE, 32'(md));
            sink.cnt = 0;
            wr(IDX_COMMAND_WORD, LAUNCH_AND_BLOCK_CODE);
            close_run(RESULT_DONE, 32'h1);
            chk(32'(sink.cnt), 32'h2);
            for (int i = 0; i < 2; i++)
            begin
                k = md[0] ? 2 * i : i;
                chk(sink.cap[0][i], smp(0, k));
                if (md[0])
                    chk(sink.cap[1][i], smp(0, k + 1));
                if (md[1])
                    chk(sink.cap[2][i], smp(1, k));
                if (md == 3)
                    chk(sink.cap[3][i], smp(1, k + 1));
            end
        end
        wr(IDX_TRIGGER_CFG, 32'h1);
        wr(IDX_WAIT_LIMIT_MS, 32'h2);
        wr(IDX_COMMAND_WORD, LAUNCH_AND_BLOCK_CODE);
        rd(IDX_RUN_STATUS, 32'h2);
        close_run(RESULT_TIMEOUT, 32'h2);
        wr(IDX_WAIT_LIMIT_MS, 32'h0);
        wr(IDX_COMMAND_WORD, LAUNCH_AND_BLOCK_CODE);
        rd(IDX_RUN_STATUS, 32'h2);
        sink.fire();
        close_run(RESULT_DONE, 32'h1);
        wr(IDX_EVENT_MASK, 32'h0);
        wr(IDX_COMMAND_WORD, LAUNCH_AND_BLOCK_CODE);
        wr(IDX_COMMAND_WORD, HALT_CODE);
        rd(IDX_RUN_STATUS, 32'h1);
        chk({31'h0, irq_o}, 32'h0);
        wr(IDX_EVENT_MASK, 32'h7);
        close_run(RESULT_HALTED, 32'h4);
        wr(IDX_COMMAND_WORD, HALT_CODE);
        rd(IDX_EVENT_STATUS, 32'h0);
        rd(IDX_WAIT_RESULT, RESULT_HALTED);
        finish_test;
    end
endmodule // replay_core_bench
